// [core/tpc_cfg.svh]
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH

// Byte addresses of the register window
`define TPC_A_TSC 8'h00
`define TPC_A_CNTH 8'h01
`define TPC_A_CNTL 8'h02
`define TPC_A_MODH 8'h03
`define TPC_A_MODL 8'h04
`define TPC_A_CH_BASE 8'h05
`define TPC_CH_STRIDE 3
`define TPC_CH_CS 0
`define TPC_CH_VH 1
`define TPC_CH_VL 2

// Timer status/control fields
`define TPC_TSC_TOF 7
`define TPC_TSC_OVERFLOW_IRQ_ENABLE 6
`define TPC_TSC_CENTER_ALIGN_SELECT 5
`define TPC_TSC_CLKS_HI 4
`define TPC_TSC_CLKS_LO 3
`define TPC_TSC_PS_HI 2
`define TPC_TSC_RST 8'h00

// Clock source codes
`define TPC_CLKS_OFF 2'h0
`define TPC_CLKS_BUS 2'h1
`define TPC_CLKS_FIX 2'h2
`define TPC_CLKS_EXT 2'h3

// Channel status/control fields
`define TPC_CS_FLAG 7
`define TPC_CS_IE 6
`define TPC_CS_MSB 5
`define TPC_CS_MSA 4
`define TPC_CS_ELS_HI 3
`define TPC_CS_ELS_LO 2
`define TPC_CS_RST 7'h00

// Counter values
`define TPC_VAL_RST 16'h0000
`define TPC_CNT_MAX 16'hffff

`endif

// [core/tpc_channel.sv]
`timescale 1ns/10ps
`include "tpc_cfg.svh"

module tpc_channel
  import tpc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] wdata_in,
  input wire logic cs_wr_in,
  input wire logic cs_rd_in,
  input wire logic vh_wr_in,
  input wire logic vl_wr_in,
  input wire logic vh_rd_in,
  input wire logic vl_rd_in,
  input wire logic [15:0] cnt_in,
  input wire logic cnt_new_in,
  input wire logic ovf_in,
  input wire logic dir_up_in,
  input wire logic center_align_select_in,
  input wire logic pin_in,
  output logic [7:0] cs_out,
  output logic [15:0] rd_val_out,
  output logic pin_out,
  output logic pin_oe_out
);

  logic [6:0] ctl_q, ctl_d;
  logic flag_q, flag_d, arm_q, arm_d;
  logic [15:0] val_q, val_d, buf_q, buf_d, snap_q, snap_d;
  logic hw_q, hw_d, lw_q, lw_d, lat_q, lat_d, lhi_q, lhi_d;
  logic s1_q, s2_q, s3_q;
  logic pin_q, pin_d, oe_q, oe_d;
  logic [1:0] els;
  logic rise, fall, cap_evt, match, evt;
  tpc_chmode_t mode;

  assign els = ctl_q[`TPC_CS_ELS_HI:`TPC_CS_ELS_LO];
  assign mode = tpc_mode(center_align_select_in, ctl_q[`TPC_CS_MSB:`TPC_CS_MSA]);
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;
  assign cap_evt = (mode == CM_CAP) & ((els[0] & rise) | (els[1] & fall));
  assign match = (mode != CM_CAP) & cnt_new_in & (cnt_in == val_q);
  assign evt = cap_evt | match;
  assign cs_out = {flag_q, ctl_q};
  assign rd_val_out = lat_q ? snap_q : val_q;
  assign pin_out = pin_q;
  assign pin_oe_out = oe_q;

  always_comb begin
    ctl_d = ctl_q;
    flag_d = flag_q;
    arm_d = arm_q;
    val_d = val_q;
    buf_d = buf_q;
    hw_d = hw_q;
    lw_d = lw_q;
    snap_d = snap_q;
    lat_d = lat_q;
    lhi_d = lhi_q;
    if (cs_rd_in && flag_q) begin
      arm_d = 1'b1;
    end
    if (cs_wr_in) begin
      ctl_d = wdata_in[6:0];
      hw_d = 1'b0;
      lw_d = 1'b0;
      lat_d = 1'b0;
      if (!wdata_in[`TPC_CS_FLAG] && arm_q) begin
        flag_d = 1'b0;
      end
      arm_d = 1'b0;
    end else if (mode == CM_CAP) begin
      if (vh_wr_in) begin
        val_d[15:8] = wdata_in;
      end
      if (vl_wr_in) begin
        val_d[7:0] = wdata_in;
      end
      if ((vh_rd_in || vl_rd_in) && !lat_q) begin
        snap_d = val_q;
        lat_d = 1'b1;
        lhi_d = vh_rd_in;
      end else if ((lhi_q ? vl_rd_in : vh_rd_in) && lat_q) begin
        lat_d = 1'b0;
      end
    end else begin
      if (vh_wr_in) begin
        buf_d[15:8] = wdata_in;
        hw_d = 1'b1;
      end
      if (vl_wr_in) begin
        buf_d[7:0] = wdata_in;
        lw_d = 1'b1;
      end
      if (hw_q && lw_q && ((mode == CM_OC) || ovf_in)) begin
        val_d = buf_q;
        hw_d = vh_wr_in;
        lw_d = vl_wr_in;
      end
    end
    if (cap_evt) begin
      val_d = cnt_in;
    end
    if (evt) begin
      flag_d = 1'b1;
      arm_d = 1'b0;
    end
  end

  always_comb begin
    pin_d = pin_q;
    oe_d = (els != 2'b00) && (mode != CM_CAP);
    unique case (mode)
      CM_CAP: pin_d = 1'b0;
      CM_OC: begin
        if (match) begin
          unique case (els)
            2'b01: pin_d = ~pin_q;
            2'b10: pin_d = 1'b0;
            2'b11: pin_d = 1'b1;
            2'b00: pin_d = pin_q;
          endcase
        end
      end
      CM_EPWM: begin
        if (ovf_in) begin
          pin_d = ~els[0];
        end
        if (match) begin
          pin_d = els[0];
        end
      end
      CM_CPWM: begin
        if (match) begin
          pin_d = dir_up_in ? els[0] : ~els[0];
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ctl_q <= `TPC_CS_RST;
      flag_q <= 1'b0;
      arm_q <= 1'b0;
      val_q <= `TPC_VAL_RST;
      buf_q <= `TPC_VAL_RST;
      snap_q <= `TPC_VAL_RST;
      hw_q <= 1'b0;
      lw_q <= 1'b0;
      lat_q <= 1'b0;
      lhi_q <= 1'b0;
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      pin_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      flag_q <= flag_d;
      arm_q <= arm_d;
      val_q <= val_d;
      buf_q <= buf_d;
      snap_q <= snap_d;
      hw_q <= hw_d;
      lw_q <= lw_d;
      lat_q <= lat_d;
      lhi_q <= lhi_d;
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
      oe_q <= oe_d;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_cap_first_rd;
    (mode == CM_CAP) && (vh_rd_in || vl_rd_in) && !lat_q && !cs_wr_in && !cap_evt;
  endsequence

  a_capture_copy: assert property (cap_evt |=> (val_q == $past(cnt_in)) && flag_q)
    else $error("capture did not copy the counter");
  a_els_release: assert property ((els == 2'b00) |=> !pin_oe_out)
    else $error("pin driven with edge/level 00");
  a_flag_set: assert property (evt |=> flag_q)
    else $error("channel flag missed an event");
  a_rd_freeze: assert property (s_cap_first_rd |=> lat_q && (rd_val_out == $past(val_q)))
    else $error("capture value not frozen on read");
  a_half_write: assert property ((mode != CM_CAP) && vh_wr_in && !lw_q && !cs_wr_in
      |=> $stable(val_q))
    else $error("single byte write reached the active value");
  a_oc_set: assert property ((mode == CM_OC) && (els == 2'b11) && match |=> pin_out)
    else $error("set on compare failed");

endmodule

// [core/tpc_pkg.sv]
package tpc_pkg;

  typedef enum logic [3:0] {
    CM_CAP = 4'b0001,
    CM_OC = 4'b0010,
    CM_EPWM = 4'b0100,
    CM_CPWM = 4'b1000
  } tpc_chmode_t;

  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DN = 2'b10
  } tpc_dir_t;

  function automatic tpc_chmode_t tpc_mode(input logic center_align_select, input logic [1:0] ms);
    if (center_align_select) begin
      return CM_CPWM;
    end else if (ms[1]) begin
      return CM_EPWM;
    end else if (ms[0]) begin
      return CM_OC;
    end
    return CM_CAP;
  endfunction

endpackage

// [core/tpc_timer.sv]
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "tpc_cfg.svh"

// Overview of operation
// - Capture mode: edge/level 01 rising, 10 falling, 11 either edge.
// - Compare mode: 00 software only, 01 toggle, 10 clear, 11 set on match.
// - Edge PWM: code 10 high-true clear on compare; low bit set gives low-true.
// - Center PWM: 10 clears on up-match; low bit set sets on up-match.
// - Edge/level 00 releases the channel pin whatever the mode bits.
// - Channel value is a 16-bit read/write byte pair, cleared by reset.
// - Capture mode: reading one value byte freezes both until the other is read.
// - Compare/PWM: value bytes buffered, moved after both written; control write resets.
// - Center-align makes the counter up/down and all channels center PWM.
// - Clock select resets to off; 01 is bus clock, others fixed or external.
// - Counter halts in background debug and stop, runs in wait.
// - Up mode counts 0 to modulus or 0xFFFF, then wraps to zero.
// - Up/down mode counts 0 to modulus and back; endpoints one tick each.
// - Overflow interrupt is a level while flag and enable are both set.
// - Up mode sets the overflow flag on the wrap to zero.
// - Up/down mode sets the overflow flag when stepping down from modulus.
// - Reading a counter byte captures both bytes until both are read.
// - Any counter byte write zeroes the counter and clears its read latch.
// - An active capture edge copies the counter into the channel value.
// - Channel flag sets on capture or match; interrupt while flag and enable.

module tpc_timer
  import tpc_pkg::*;
#(
  parameter int NCH = 2
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic bdm_active_in,
  input wire logic stop_mode_in,
  input wire logic fixed_clk_in,
  input wire logic ext_clk_in,
  input wire logic [NCH-1:0] ch_pin_in,
  output logic [NCH-1:0] ch_pin_out,
  output logic [NCH-1:0] ch_pin_oe_out,
  output logic tof_irq_out,
  output logic [NCH-1:0] ch_irq_out
);

  function automatic logic [7:0] ch_addr(input int ch, input int sub);
    return 8'(int'(`TPC_A_CH_BASE) + `TPC_CH_STRIDE * ch + sub);
  endfunction

  function automatic logic [6:0] ps_mask(input logic [2:0] ps);
    return 7'((8'h01 << ps) - 8'h01);
  endfunction

  function automatic logic [7:0] pick(input logic [15:0] v, input logic hi);
    return hi ? v[15:8] : v[7:0];
  endfunction

  // Register state
  logic [7:0] tsc_q, tsc_d;
  logic tof_arm_q, tof_arm_d;
  logic [15:0] mod_q, mod_d, mbuf_q, mbuf_d;
  logic mhw_q, mhw_d, mlw_q, mlw_d;
  logic [15:0] cnt_q, cnt_d, snap_q, snap_d;
  logic lat_q, lat_d, lhi_q, lhi_d;
  tpc_dir_t dir_q, dir_d;
  logic [6:0] pre_q, pre_d;
  logic cnt_new_q, ovf_q;
  logic [7:0] rdata_q, rdata_d;
  logic tof_irq_q;
  logic [NCH-1:0] ch_irq_q;
  logic fix_s1_q, fix_s2_q, fix_s3_q;
  logic ext_s1_q, ext_s2_q, ext_s3_q;

  // Decoded strobes and counter controls
  logic tsc_wr, tsc_rd, cnt_wr, cnt_rd;
  logic center_align_select, src_tick, pre_tick, cnt_en, tof_evt;
  logic [1:0] clks;
  logic [15:0] term;
  logic [NCH-1:0] cs_wr, cs_rd, vh_wr, vl_wr, vh_rd, vl_rd;
  logic [7:0] ch_cs [NCH];
  logic [15:0] ch_rv [NCH];

  assign tsc_wr = wr_in && (addr_in == `TPC_A_TSC);
  assign tsc_rd = rd_in && (addr_in == `TPC_A_TSC);
  assign cnt_wr = wr_in && ((addr_in == `TPC_A_CNTH) || (addr_in == `TPC_A_CNTL));
  assign cnt_rd = rd_in && ((addr_in == `TPC_A_CNTH) || (addr_in == `TPC_A_CNTL));
  assign center_align_select = tsc_q[`TPC_TSC_CENTER_ALIGN_SELECT];
  assign clks = tsc_q[`TPC_TSC_CLKS_HI:`TPC_TSC_CLKS_LO];
  assign term = (mod_q != 16'h0000) ? mod_q : `TPC_CNT_MAX;

  always_comb begin
    cs_wr = '0;
    cs_rd = '0;
    vh_wr = '0;
    vl_wr = '0;
    vh_rd = '0;
    vl_rd = '0;
    for (int i = 0; i < NCH; i++) begin
      cs_wr[i] = wr_in && (addr_in == ch_addr(i, `TPC_CH_CS));
      cs_rd[i] = rd_in && (addr_in == ch_addr(i, `TPC_CH_CS));
      vh_wr[i] = wr_in && (addr_in == ch_addr(i, `TPC_CH_VH));
      vl_wr[i] = wr_in && (addr_in == ch_addr(i, `TPC_CH_VL));
      vh_rd[i] = rd_in && (addr_in == ch_addr(i, `TPC_CH_VH));
      vl_rd[i] = rd_in && (addr_in == ch_addr(i, `TPC_CH_VL));
    end
  end

  // Clock source selection, prescaler and halt
  always_comb begin
    pre_d = pre_q;
    pre_tick = 1'b0;
    unique case (clks)
      `TPC_CLKS_OFF: src_tick = 1'b0;
      `TPC_CLKS_BUS: src_tick = 1'b1;
      `TPC_CLKS_FIX: src_tick = fix_s2_q & ~fix_s3_q;
      `TPC_CLKS_EXT: src_tick = ext_s2_q & ~ext_s3_q;
    endcase
    if (src_tick && !bdm_active_in && !stop_mode_in) begin
      pre_d = pre_q + 7'h01;
      pre_tick = (pre_q & ps_mask(tsc_q[`TPC_TSC_PS_HI:0])) ==
                 ps_mask(tsc_q[`TPC_TSC_PS_HI:0]);
    end
    if (cnt_wr) begin
      pre_d = 7'h00;
    end
    cnt_en = pre_tick && !cnt_wr;
  end

  // Main counter
  always_comb begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    tof_evt = 1'b0;
    if (cnt_wr) begin
      cnt_d = 16'h0000;
      dir_d = DIR_UP;
    end else if (cnt_en && !center_align_select) begin
      dir_d = DIR_UP;
      if (cnt_q == term) begin
        cnt_d = 16'h0000;
        tof_evt = 1'b1;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end else if (cnt_en) begin
      unique case (dir_q)
        DIR_UP: begin
          if (cnt_q == mod_q) begin
            cnt_d = cnt_q - 16'h0001;
            dir_d = DIR_DN;
            tof_evt = 1'b1;
          end else begin
            cnt_d = cnt_q + 16'h0001;
          end
        end
        DIR_DN: begin
          if (cnt_q == 16'h0000) begin
            cnt_d = 16'h0001;
            dir_d = DIR_UP;
          end else begin
            cnt_d = cnt_q - 16'h0001;
          end
        end
      endcase
    end
  end

  // Counter read coherency
  always_comb begin
    snap_d = snap_q;
    lat_d = lat_q;
    lhi_d = lhi_q;
    if (cnt_wr) begin
      lat_d = 1'b0;
    end else if (cnt_rd && !lat_q) begin
      snap_d = cnt_q;
      lat_d = 1'b1;
      lhi_d = (addr_in == `TPC_A_CNTH);
    end else if (cnt_rd && (lhi_q != (addr_in == `TPC_A_CNTH))) begin
      lat_d = 1'b0;
    end
  end

  // Status/control and modulus
  always_comb begin
    tsc_d = tsc_q;
    tof_arm_d = tof_arm_q;
    mod_d = mod_q;
    mbuf_d = mbuf_q;
    mhw_d = mhw_q;
    mlw_d = mlw_q;
    if (tsc_rd && tsc_q[`TPC_TSC_TOF]) begin
      tof_arm_d = 1'b1;
    end
    if (tsc_wr) begin
      tsc_d[6:0] = wdata_in[6:0];
      if (!wdata_in[`TPC_TSC_TOF] && tof_arm_q) begin
        tsc_d[`TPC_TSC_TOF] = 1'b0;
      end
      tof_arm_d = 1'b0;
      mhw_d = 1'b0;
      mlw_d = 1'b0;
    end else begin
      if (wr_in && (addr_in == `TPC_A_MODH)) begin
        mbuf_d[15:8] = wdata_in;
        mhw_d = 1'b1;
      end
      if (wr_in && (addr_in == `TPC_A_MODL)) begin
        mbuf_d[7:0] = wdata_in;
        mlw_d = 1'b1;
      end
      if (mhw_q && mlw_q) begin
        mod_d = mbuf_q;
        mhw_d = 1'b0;
        mlw_d = 1'b0;
      end
    end
    if (tof_evt) begin
      tsc_d[`TPC_TSC_TOF] = 1'b1;
      tof_arm_d = 1'b0;
    end
  end

  // Read data, one cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        `TPC_A_TSC: rdata_d = tsc_q;
        `TPC_A_CNTH: rdata_d = pick(lat_q ? snap_q : cnt_q, 1'b1);
        `TPC_A_CNTL: rdata_d = pick(lat_q ? snap_q : cnt_q, 1'b0);
        `TPC_A_MODH: rdata_d = mod_q[15:8];
        `TPC_A_MODL: rdata_d = mod_q[7:0];
        default: begin
          for (int i = 0; i < NCH; i++) begin
            if (cs_rd[i]) begin
              rdata_d = ch_cs[i];
            end
            if (vh_rd[i] || vl_rd[i]) begin
              rdata_d = pick(ch_rv[i], vh_rd[i]);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      tsc_q <= `TPC_TSC_RST;
      tof_arm_q <= 1'b0;
      mod_q <= `TPC_VAL_RST;
      mbuf_q <= `TPC_VAL_RST;
      mhw_q <= 1'b0;
      mlw_q <= 1'b0;
      cnt_q <= `TPC_VAL_RST;
      snap_q <= `TPC_VAL_RST;
      lat_q <= 1'b0;
      lhi_q <= 1'b0;
      dir_q <= DIR_UP;
      pre_q <= 7'h00;
      cnt_new_q <= 1'b0;
      ovf_q <= 1'b0;
      rdata_q <= 8'h00;
      tof_irq_q <= 1'b0;
      ch_irq_q <= '0;
      fix_s1_q <= 1'b0;
      fix_s2_q <= 1'b0;
      fix_s3_q <= 1'b0;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      tsc_q <= tsc_d;
      tof_arm_q <= tof_arm_d;
      mod_q <= mod_d;
      mbuf_q <= mbuf_d;
      mhw_q <= mhw_d;
      mlw_q <= mlw_d;
      cnt_q <= cnt_d;
      snap_q <= snap_d;
      lat_q <= lat_d;
      lhi_q <= lhi_d;
      dir_q <= dir_d;
      pre_q <= pre_d;
      cnt_new_q <= cnt_en;
      ovf_q <= tof_evt;
      rdata_q <= rdata_d;
      tof_irq_q <= tsc_q[`TPC_TSC_TOF] & tsc_q[`TPC_TSC_OVERFLOW_IRQ_ENABLE];
      for (int i = 0; i < NCH; i++) begin
        ch_irq_q[i] <= ch_cs[i][`TPC_CS_FLAG] & ch_cs[i][`TPC_CS_IE];
      end
      fix_s1_q <= fixed_clk_in;
      fix_s2_q <= fix_s1_q;
      fix_s3_q <= fix_s2_q;
      ext_s1_q <= ext_clk_in;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    tpc_channel u_ch (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .wdata_in(wdata_in),
      .cs_wr_in(cs_wr[g]),
      .cs_rd_in(cs_rd[g]),
      .vh_wr_in(vh_wr[g]),
      .vl_wr_in(vl_wr[g]),
      .vh_rd_in(vh_rd[g]),
      .vl_rd_in(vl_rd[g]),
      .cnt_in(cnt_q),
      .cnt_new_in(cnt_new_q),
      .ovf_in(ovf_q),
      .dir_up_in(dir_q == DIR_UP),
      .center_align_select_in(center_align_select),
      .pin_in(ch_pin_in[g]),
      .cs_out(ch_cs[g]),
      .rd_val_out(ch_rv[g]),
      .pin_out(ch_pin_out[g]),
      .pin_oe_out(ch_pin_oe_out[g])
    );
  end

  assign rdata_out = rdata_q;
  assign tof_irq_out = tof_irq_q;
  assign ch_irq_out = ch_irq_q;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_first_cnt_rd;
    cnt_rd && !lat_q && !cnt_wr;
  endsequence

  sequence s_at_top;
    cnt_en && center_align_select && (dir_q == DIR_UP) && (cnt_q == mod_q) && (mod_q != 16'h0000);
  endsequence

  a_tof_wrap: assert property (cnt_en && !center_align_select && (cnt_q == term)
      |=> (cnt_q == 16'h0000) && tsc_q[`TPC_TSC_TOF])
    else $error("up-count wrap did not set overflow flag");
  a_tof_irq: assert property (tsc_q[`TPC_TSC_TOF] && tsc_q[`TPC_TSC_OVERFLOW_IRQ_ENABLE] |=> tof_irq_out)
    else $error("overflow interrupt not raised");
  a_tof_noirq: assert property (!tsc_q[`TPC_TSC_OVERFLOW_IRQ_ENABLE] |=> !tof_irq_out)
    else $error("overflow interrupt raised while disabled");
  a_updown_rev: assert property (s_at_top
      |=> (cnt_q == $past(mod_q) - 16'h0001) && (dir_q == DIR_DN) && tsc_q[`TPC_TSC_TOF])
    else $error("up/down reversal wrong");
  a_cnt_clear: assert property (cnt_wr |=> (cnt_q == 16'h0000) && !lat_q)
    else $error("counter write did not clear");
  a_clk_off: assert property ((clks == `TPC_CLKS_OFF) && !cnt_wr |=> $stable(cnt_q))
    else $error("counter moved with clock off");
  a_bdm_halt: assert property (bdm_active_in && !cnt_wr |=> $stable(cnt_q))
    else $error("counter moved in debug halt");
  a_cnt_freeze: assert property (s_first_cnt_rd |=> lat_q && (snap_q == $past(cnt_q)))
    else $error("counter read not captured");

endmodule

// [tb/test_timer_pwm_counter_channels.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end

module test_timer_pwm_counter_channels;
  import tpc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic wr = 1'b0, rd = 1'b0, rd_q = 1'b0, bdm = 1'b0, fix = 1'b0, ext, tofirq;
  logic stop = 1'b0;
  logic [1:0] drv = 2'h0, pout, poe, plvl, chirq;
  logic [15:0] expq[$];
  logic [7:0] seed = 8'h59;
  int error_cnt = 0;
  int comparisons = 0;

  tpc_timer #(.NCH(2)) u_dut (.mclk_in(clk), .sys_rst_in(rst), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .bdm_active_in(bdm),
    .stop_mode_in(stop), .fixed_clk_in(fix), .ext_clk_in(ext), .ch_pin_in(plvl),
    .ch_pin_out(pout), .ch_pin_oe_out(poe), .tof_irq_out(tofirq), .ch_irq_out(chirq));
  tpc_pin_model #(.NCH(2)) u_pins (.mclk_in(clk), .drv_in(drv), .pin_out_in(pout),
    .pin_oe_in(poe), .pin_lvl_out(plvl), .ext_clk_out(ext));

  initial begin
    forever #12.5 clk = ~clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    logic [15:0] n;
    if (rd_q) begin
      n = expq.pop_front();
      `CHK(rdata & n[7:0], n[15:8])
    end
    rd_q <= rd;
    seed <= lfsr(seed);
    fix <= seed[0];
  end

  task automatic print_verdict();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd8(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    expq.push_back({e, m});
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic sig(input int s);
    return s == 2 ? tofirq : s == 3 ? poe[0] : s == 4 ? chirq[1] : plvl[s];
  endfunction

  // Bounded wait; running out ends the run
  task automatic wt(input int s, input logic v);
    int i;
    for (i = 0; i < 40 && sig(s) !== v; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK(sig(s), v)
    if (sig(s) !== v) print_verdict();
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd8(8'h00, 8'h00, 8'hff);
    rd8(8'h06, 8'h00, 8'hff);
    rd8(8'h07, 8'h00, 8'hff);
    rd8(8'hff, 8'h00, 8'hff);
    repeat (20) @(posedge clk);
    rd8(8'h02, 8'h00, 8'hff);
    rd8(8'h01, 8'h00, 8'hff);
    wr8(8'h06, 8'ha5);
    wr8(8'h07, 8'h3c);
    rd8(8'h06, 8'ha5, 8'hff);
    rd8(8'h07, 8'h3c, 8'hff);
    // Counter snapshot survives a long run
    bdm <= 1'b1;
    wr8(8'h00, 8'h08);
    wr8(8'h01, 8'h77);
    rd8(8'h02, 8'h00, 8'hff);
    bdm <= 1'b0;
    repeat (300) @(posedge clk);
    bdm <= 1'b1;
    rd8(8'h01, 8'h00, 8'hff);
    rd8(8'h01, 8'h01, 8'hff);
    rd8(8'h02, 8'h2c, 8'hff);
    // Capture on each edge code, both edge directions
    for (int k = 1; k < 4; k++) begin
      wr8(8'h08, 8'(k * 4));
      for (int e = 0; e < 2; e++) begin
        repeat (4) @(posedge clk);
        drv[1] <= ~drv[1];
        repeat (8) @(posedge clk);
        rd8(8'h08, {k[e], 3'h0, k[1:0], 2'h0}, 8'hff);
        wr8(8'h08, 8'(k * 4));
      end
    end
    rd8(8'h09, 8'h01, 8'hff);
    rd8(8'h0a, 8'h2c, 8'hff);
    // Channel interrupt follows flag and enable
    wr8(8'h08, 8'h4c);
    repeat (4) @(posedge clk);
    drv[1] <= ~drv[1];
    wt(4, 1'b1);
    rd8(8'h08, 8'hcc, 8'hff);
    wr8(8'h08, 8'h0c);
    wt(4, 1'b0);
    // Modulus 3 overflow and flag clear
    wr8(8'h04, 8'h03);
    wr8(8'h03, 8'h00);
    wr8(8'h00, 8'h48);
    wr8(8'h01, 8'h00);
    bdm <= 1'b0;
    wt(2, 1'b1);
    bdm <= 1'b1;
    rd8(8'h01, 8'h00, 8'hff);
    rd8(8'h02, 8'h00, 8'hfc);
    rd8(8'h00, 8'hc8, 8'hff);
    wr8(8'h00, 8'h08);
    wt(2, 1'b0);
    rd8(8'h00, 8'h08, 8'hff);
    // Compare on channel 0, value bytes buffered
    wr8(8'h05, 8'h14);
    wr8(8'h07, 8'h02);
    bdm <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    `CHK(plvl[0], 1'b0)
    wr8(8'h06, 8'h00);
    wt(0, 1'b1);
    wt(0, 1'b0);
    wr8(8'h05, 8'h1c);
    wt(0, 1'b1);
    wr8(8'h05, 8'h18);
    wt(0, 1'b0);
    for (int p = 0; p < 2; p++) begin
      wr8(8'h05, p ? 8'h24 : 8'h28);
      wt(0, 1'b1);
      wt(0, 1'b0);
    end
    wr8(8'h05, 8'h20);
    wt(3, 1'b0);
    // Center-aligned mode with overflow at the turn
    wr8(8'h05, 8'h18);
    bdm <= 1'b1;
    rd8(8'h00, 8'h88, 8'hff);
    wr8(8'h00, 8'h68);
    rd8(8'h00, 8'h68, 8'hff);
    bdm <= 1'b0;
    wt(0, 1'b1);
    wt(0, 1'b0);
    wt(2, 1'b1);
    // Stop mode halts; external and fixed clocks step the counter
    stop <= 1'b1;
    wr8(8'h03, 8'h00);
    wr8(8'h04, 8'h00);
    wr8(8'h00, 8'h18);
    wr8(8'h01, 8'h00);
    repeat (40) @(posedge clk);
    rd8(8'h02, 8'h00, 8'hff);
    rd8(8'h01, 8'h00, 8'hff);
    stop <= 1'b0;
    wr8(8'h01, 8'h00);
    repeat (40) @(posedge clk);
    rd8(8'h02, 8'h08, 8'hf8);
    rd8(8'h01, 8'h00, 8'hff);
    wr8(8'h00, 8'h10);
    wr8(8'h01, 8'h00);
    repeat (40) @(posedge clk);
    rd8(8'h02, 8'h00, 8'he0);
    rd8(8'h01, 8'h00, 8'hff);
    repeat (2) @(posedge clk);
    `CHK(expq.size(), 0)
    print_verdict();
  end
endmodule

// [tb/tpc_pin_model.sv]
`timescale 1ns/10ps

module tpc_pin_model #(
  parameter int NCH = 2
) (
  input wire logic mclk_in,
  input wire logic [NCH-1:0] drv_in,
  input wire logic [NCH-1:0] pin_out_in,
  input wire logic [NCH-1:0] pin_oe_in,
  output logic [NCH-1:0] pin_lvl_out,
  output logic ext_clk_out
);
  logic [1:0] div_q = 2'h0;

  // Timer owns the wire while enabled, otherwise the outside source
  assign pin_lvl_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & drv_in);

  // External clock kept at a quarter of the bus clock
  always @(posedge mclk_in) begin
    div_q <= div_q + 2'h1;
  end
  assign ext_clk_out = div_q[1];
endmodule
